// [pkg/csbu_pkg.sv]
// Purpose: shared constants and codes of the compare, shift and branch unit
// Assumes: big-endian bit numbering, bit 0 is the most significant bit of a word
// Notes: op codes are internal to the unit, not instruction opcodes
package csbu_pkg;
    localparam int WORD_W = 32;
    localparam int PAIR_W = 64;
    localparam int CNT_W = 6;
    localparam int FIELD_W = 4;
    localparam int SHORT_DISP_W = 16;
    localparam int SHORT_DISP_LSB = 16;
    localparam int BYTE_SIGN_BIT = 24;
    localparam int HALF_SIGN_BIT = 16;
    localparam int SIGN_BIT = 0;
    localparam int PRED_BIT = 31;
    localparam int REFILL_MIN = 2;
    localparam int REFILL_MAX = 4;
    localparam logic [0:31] RES_LESS = 32'hffff_ffff;
    localparam logic [0:31] RES_EQUAL = 32'h0000_0000;
    localparam logic [0:31] RES_GREATER = 32'h0000_0001;
    localparam logic [0:31] LEN_REG = 32'h0000_0002;
    localparam logic [0:31] LEN_SHORT = 32'h0000_0004;
    localparam logic [0:31] LEN_LONG = 32'h0000_0006;
    localparam logic [0:31] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_UNSIGNED_COMPARE = 5'h01,
        OP_PAIR_SIGNED_COMPARE = 5'h02,
        OP_SINGLE_REAL_COMPARE = 5'h03,
        OP_DOUBLE_REAL_COMPARE = 5'h04,
        OP_ROTATE_LEFT = 5'h05,
        OP_ZERO_FILL_LEFT_SHIFT = 5'h06,
        OP_ZERO_FILL_RIGHT_SHIFT = 5'h07,
        OP_SIGN_KEEP_LEFT_SHIFT = 5'h08,
        OP_SIGN_FILL_RIGHT_SHIFT = 5'h09,
        OP_PAIR_LEFT_SHIFT = 5'h0a,
        OP_PAIR_RIGHT_SHIFT = 5'h0b,
        OP_BYTE_SIGN_EXTEND = 5'h0c,
        OP_HALFWORD_SIGN_EXTEND = 5'h0d,
        OP_RELATIVE_JUMP = 5'h0e,
        OP_COND_JUMP = 5'h0f,
        OP_LOOP_JUMP = 5'h10,
        OP_CALL = 5'h11,
        OP_REGISTER_RELATIVE_SUBROUTINE_JUMP = 5'h12,
        OP_ABSOLUTE_REGISTER_JUMP = 5'h13
    } csbu_op_t;

    typedef enum logic [2:0] {
        REL_EQ = 3'h0,
        REL_LT = 3'h1,
        REL_GT = 3'h2,
        REL_NE = 3'h3,
        REL_LE = 3'h4,
        REL_GE = 3'h5
    } csbu_rel_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_REFILL = 2'b10
    } csbu_state_t;
endpackage : csbu_pkg

// [rtl/csbu_barrel.sv]
// Purpose: 64-bit logarithmic barrel shifter
// Assumes: bit 0 is the most significant bit; count is at most 63
// Notes: pure combinational, same depth for every count
`timescale 1ns/1ps
`default_nettype none
module csbu_barrel #(
    parameter int W = 64,
    parameter int CW = 6
) (
    input wire logic [0:W-1] data_in, // value to shift
    input wire logic [CW-1:0] count, // shift distance
    input wire logic dir_left, // 1 shifts toward bit 0
    input wire logic fill_bit, // bit entering from the top on right shifts
    output logic [0:W-1] data_out // shifted value
);
    logic [0:W-1] stage [0:CW];

    assign stage[0] = data_in;

    // one stage per count bit so the delay never depends on the count
    genvar i;
    generate
        for (i = 0; i < CW; i++) begin : g_stage
            localparam int K = 1 << i;
            wire [0:W-1] left_v = {stage[i][K:W-1], {K{1'b0}}};
            wire [0:W-1] right_v = {{K{fill_bit}}, stage[i][0:W-1-K]};
            assign stage[i+1] = !count[i] ? stage[i] : (dir_left ? left_v : right_v);
        end
    endgenerate

    assign data_out = stage[CW];
endmodule : csbu_barrel
`default_nettype wire

// [rtl/csbu_unit.sv]
// Purpose: compare, shift, sign-extend and program control execution
// Assumes: operands arrive synchronous to clk_sys; pair = {even word, odd word}
// Notes: one operation per accepted cycle, results one cycle later
`timescale 1ns/1ps
`default_nettype none
// How it works
// - unsigned compare gives -1, 0 or +1
// - signed 64-bit pair compare gives -1/0/+1
// - single real sign-magnitude compare gives -1/0/+1
// - double real sign-magnitude compare gives -1/0/+1
// - every shift takes one cycle, any count
// - register count uses low 5 or 6 bits
// - immediate shift count is the 4-bit field
// - rotate left: bit 0 re-enters at 31
// - logical single shifts fill with zeros
// - arithmetic right copies sign; left keeps sign
// - pair shifts act on one 64-bit value
// - byte sign extend replicates bit 24
// - halfword sign extend replicates bit 16
// - target is pc plus sign-extended displacement
// - displacement lsb predicts conditional branch prefetch
// - wrong prediction stalls two to four cycles
// - unconditional branch always prefetches its target
// - conditional branch: signed relation, register or field
// - loop adds field, writes back, branches if negative
// - call saves next address, jumps pc-relative
// - register call saves pc+2, jumps pc+register
// - return saves pc+2, jumps to register
module csbu_unit #(
    parameter int REFILL_CYCLES = csbu_pkg::REFILL_MIN
) (
    input wire logic clk_sys, // processor clock
    input wire logic nrst, // asynchronous reset, active low
    input wire logic op_valid, // operation presented
    input wire csbu_pkg::csbu_op_t op_code, // operation
    input wire logic op_imm, // second operand is the 4-bit field
    input wire csbu_pkg::csbu_rel_t op_rel, // relation of a conditional branch
    input wire logic op_long, // long displacement format
    input wire logic [0:31] pc, // address of this instruction
    input wire logic [0:31] x_val, // first operand register
    input wire logic [0:31] x_pair_val, // odd word of first_operand_pair
    input wire logic [0:31] y_val, // second_operand_register
    input wire logic [0:31] y_pair_val, // odd word of second_operand_pair
    input wire logic [3:0] y_field, // second operand field
    input wire logic [0:31] disp, // displacement, short form in bits 16-31
    output logic op_ready, // operation accepted when high
    output logic res_valid, // results below valid, one cycle
    output logic x_wr_en, // write first operand register
    output logic [0:31] x_wr_data, // value for first operand register
    output logic pair_wr_en, // write odd word of the pair
    output logic [0:31] pair_wr_data, // value for odd word of the pair
    output logic pc_valid, // control transfer resolved
    output logic [0:31] pc_next, // address of next instruction
    output logic [0:31] prefetch_addr, // address prefetch was steered to
    output logic mispredict // prefetch was wrong, refill follows
);
    // reset release through two flops
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    // operation class decode
    wire is_pair_cmp = op_code == csbu_pkg::OP_PAIR_SIGNED_COMPARE;
    wire is_cmp = op_code inside {csbu_pkg::OP_UNSIGNED_COMPARE, csbu_pkg::OP_PAIR_SIGNED_COMPARE,
        csbu_pkg::OP_SINGLE_REAL_COMPARE, csbu_pkg::OP_DOUBLE_REAL_COMPARE};
    wire is_pair_sh = op_code inside {csbu_pkg::OP_PAIR_LEFT_SHIFT,
        csbu_pkg::OP_PAIR_RIGHT_SHIFT};
    wire is_shift = is_pair_sh || op_code inside {csbu_pkg::OP_ROTATE_LEFT,
        csbu_pkg::OP_ZERO_FILL_LEFT_SHIFT, csbu_pkg::OP_ZERO_FILL_RIGHT_SHIFT,
        csbu_pkg::OP_SIGN_KEEP_LEFT_SHIFT, csbu_pkg::OP_SIGN_FILL_RIGHT_SHIFT};
    wire is_ext = op_code inside {csbu_pkg::OP_BYTE_SIGN_EXTEND,
        csbu_pkg::OP_HALFWORD_SIGN_EXTEND};
    wire is_cond = op_code inside {csbu_pkg::OP_COND_JUMP, csbu_pkg::OP_LOOP_JUMP};
    wire is_rel_jump = op_code == csbu_pkg::OP_RELATIVE_JUMP;
    wire is_call = op_code == csbu_pkg::OP_CALL;
    wire is_rcall = op_code == csbu_pkg::OP_REGISTER_RELATIVE_SUBROUTINE_JUMP;
    wire is_abs_jump = op_code == csbu_pkg::OP_ABSOLUTE_REGISTER_JUMP;
    wire is_ctrl = is_cond || is_rel_jump || is_call || is_rcall || is_abs_jump;

    // sign-magnitude ordering, -0 and +0 compare equal; returns {less, equal}
    function automatic logic [1:0] smag_cmp(input logic [0:63] a, input logic [0:63] b);
        logic both_zero;
        logic lt;
        both_zero = (a[1:63] == 63'h0) && (b[1:63] == 63'h0);
        if (a[0] != b[0])
            lt = a[0];
        else if (!a[0])
            lt = a[1:63] < b[1:63];
        else
            lt = a[1:63] > b[1:63];
        smag_cmp = both_zero ? 2'b01 : {lt, a == b};
    endfunction : smag_cmp

    // compares
    wire [0:63] x_pair = {x_val, x_pair_val};
    wire [0:63] y_pair = {y_val, y_pair_val};
    wire u_lt = x_val < y_val;
    wire u_eq = x_val == y_val;
    wire p_lt = $signed(x_pair) < $signed(y_pair);
    wire p_eq = x_pair == y_pair;
    wire [1:0] r_res = smag_cmp({x_val, csbu_pkg::WORD_ZERO},
        {y_val, csbu_pkg::WORD_ZERO});
    wire [1:0] d_res = smag_cmp(x_pair, y_pair);
    logic cmp_lt;
    logic cmp_eq;
    always_comb begin
        unique case (op_code)
            csbu_pkg::OP_UNSIGNED_COMPARE: begin
                cmp_lt = u_lt;
                cmp_eq = u_eq;
            end
            csbu_pkg::OP_PAIR_SIGNED_COMPARE: begin
                cmp_lt = p_lt;
                cmp_eq = p_eq;
            end
            csbu_pkg::OP_SINGLE_REAL_COMPARE: begin
                cmp_lt = r_res[1];
                cmp_eq = r_res[0];
            end
            default: begin
                cmp_lt = d_res[1];
                cmp_eq = d_res[0];
            end
        endcase
    end
    wire [0:31] cmp_word = cmp_eq ? csbu_pkg::RES_EQUAL :
        (cmp_lt ? csbu_pkg::RES_LESS : csbu_pkg::RES_GREATER);

    // shifts: one barrel pass, the word sits in the upper half of the 64-bit path
    wire [5:0] reg_cnt = is_pair_sh ? y_val[26:31] : {1'b0, y_val[27:31]};
    wire [5:0] imm_cnt = {2'b00, y_field};
    wire [5:0] sh_cnt = op_imm ? imm_cnt : reg_cnt;
    wire sh_rot = op_code == csbu_pkg::OP_ROTATE_LEFT;
    wire sh_left = op_code inside {csbu_pkg::OP_ROTATE_LEFT, csbu_pkg::OP_ZERO_FILL_LEFT_SHIFT,
        csbu_pkg::OP_SIGN_KEEP_LEFT_SHIFT, csbu_pkg::OP_PAIR_LEFT_SHIFT};
    wire sh_fill = (op_code == csbu_pkg::OP_SIGN_FILL_RIGHT_SHIFT) &&
        x_val[csbu_pkg::SIGN_BIT];
    // rotate doubles the word so bits leaving bit 0 come back in at bit 31
    wire [0:63] sh_in = sh_rot ? {x_val, x_val} :
        (is_pair_sh ? x_pair : {x_val, csbu_pkg::WORD_ZERO});
    wire [0:63] sh_out;

    csbu_barrel #(
        .W(csbu_pkg::PAIR_W),
        .CW(csbu_pkg::CNT_W)
    ) u_barrel (
        .data_in(sh_in),
        .count(sh_cnt),
        .dir_left(sh_left),
        .fill_bit(sh_fill),
        .data_out(sh_out)
    );

    wire keep_sign = op_code == csbu_pkg::OP_SIGN_KEEP_LEFT_SHIFT;
    wire [0:31] sh_word = keep_sign ? {x_val[csbu_pkg::SIGN_BIT], sh_out[1:31]} :
        sh_out[0:31];

    // sign extension
    wire [0:31] sx_byte = {{24{y_val[csbu_pkg::BYTE_SIGN_BIT]}}, y_val[24:31]};
    wire [0:31] sx_half = {{16{y_val[csbu_pkg::HALF_SIGN_BIT]}}, y_val[16:31]};
    wire [0:31] ext_word = (op_code == csbu_pkg::OP_BYTE_SIGN_EXTEND) ? sx_byte : sx_half;

    // targets
    wire [0:31] disp_ext = op_long ? disp :
        {{csbu_pkg::SHORT_DISP_W{disp[csbu_pkg::SHORT_DISP_LSB]}}, disp[16:31]};
    wire [0:31] target = pc + disp_ext;
    wire [0:31] seq_addr = pc + (op_long ? csbu_pkg::LEN_LONG : csbu_pkg::LEN_SHORT);
    wire [0:31] reg_next = pc + csbu_pkg::LEN_REG;
    wire [0:31] rcall_target = pc + y_val;

    // conditional relation, signed, field zero-extended
    wire [0:31] rel_b = op_imm ? {28'h0, y_field} : y_val;
    wire r_lt = $signed(x_val) < $signed(rel_b);
    wire r_eq = x_val == rel_b;
    logic rel_true;
    always_comb begin
        unique case (op_rel)
            csbu_pkg::REL_EQ: rel_true = r_eq;
            csbu_pkg::REL_LT: rel_true = r_lt;
            csbu_pkg::REL_GT: rel_true = !r_lt && !r_eq;
            csbu_pkg::REL_NE: rel_true = !r_eq;
            csbu_pkg::REL_LE: rel_true = r_lt || r_eq;
            csbu_pkg::REL_GE: rel_true = !r_lt;
            default: rel_true = 1'b0;
        endcase
    end

    wire [0:31] loop_sum = x_val + {28'h0, y_field};
    wire is_loop = op_code == csbu_pkg::OP_LOOP_JUMP;
    wire cond_taken = is_loop ? loop_sum[csbu_pkg::SIGN_BIT] : rel_true;
    wire predict = disp_ext[csbu_pkg::PRED_BIT];

    // control resolution
    wire [0:31] next_addr = is_abs_jump ? y_val :
        is_rcall ? rcall_target :
        (is_rel_jump || is_call) ? target :
        cond_taken ? target : seq_addr;
    // the unconditional forms ignore the bit; register jumps resolve in place
    wire [0:31] pf_addr = (is_abs_jump || is_rcall) ? next_addr :
        (is_rel_jump || is_call) ? target :
        predict ? target : seq_addr;
    wire mis = is_cond && (cond_taken != predict);

    // written values
    wire [0:31] wr_word = is_cmp ? cmp_word :
        is_shift ? sh_word :
        is_ext ? ext_word :
        is_loop ? loop_sum :
        is_call ? seq_addr :
        reg_next;
    wire wr_x = is_cmp || is_shift || is_ext || is_loop || is_call || is_rcall || is_abs_jump;
    wire wr_pair = is_pair_sh && !is_pair_cmp;

    // refill stall after a wrong prediction
    csbu_pkg::csbu_state_t state_q;
    csbu_pkg::csbu_state_t state_d;
    logic [2:0] refill_q;
    logic [2:0] refill_d;
    logic ready_d;
    wire fire = op_valid && op_ready;
    localparam logic [2:0] REFILL_LOAD = 3'(REFILL_CYCLES - 1);

    always_comb begin
        state_d = state_q;
        refill_d = refill_q;
        ready_d = op_ready;
        unique case (state_q)
            csbu_pkg::ST_RUN: begin
                if (fire && mis) begin
                    state_d = csbu_pkg::ST_REFILL;
                    refill_d = REFILL_LOAD;
                    ready_d = 1'b0;
                end
            end
            csbu_pkg::ST_REFILL: begin
                if (refill_q == 3'h0) begin
                    state_d = csbu_pkg::ST_RUN;
                    ready_d = 1'b1;
                end else begin
                    refill_d = refill_q - 3'h1;
                end
            end
            default: begin
                state_d = csbu_pkg::ST_RUN;
                ready_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= csbu_pkg::ST_RUN;
            refill_q <= 3'h0;
            op_ready <= 1'b1;
        end else begin
            state_q <= state_d;
            refill_q <= refill_d;
            op_ready <= ready_d;
        end
    end

    // all results register together; a single cycle for every operation
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
            x_wr_en <= 1'b0;
            x_wr_data <= csbu_pkg::WORD_ZERO;
            pair_wr_en <= 1'b0;
            pair_wr_data <= csbu_pkg::WORD_ZERO;
            pc_valid <= 1'b0;
            pc_next <= csbu_pkg::WORD_ZERO;
            prefetch_addr <= csbu_pkg::WORD_ZERO;
            mispredict <= 1'b0;
        end else begin
            res_valid <= fire && (op_code != csbu_pkg::OP_NONE);
            x_wr_en <= fire && wr_x;
            x_wr_data <= wr_word;
            pair_wr_en <= fire && wr_pair;
            pair_wr_data <= sh_out[32:63];
            pc_valid <= fire && is_ctrl;
            pc_next <= next_addr;
            prefetch_addr <= pf_addr;
            mispredict <= fire && mis;
        end
    end
endmodule : csbu_unit
`default_nettype wire

// [test/csbu_unit_chk.sv]
// Purpose: concurrent checks on the ports of the compare, shift and branch unit
// Assumes: single clock domain, nrst active low
// Notes: expected values are rebuilt from the inputs of the cycle before
`timescale 1ns/1ps
`default_nettype none
module csbu_unit_chk #(
    parameter int REFILL_CYCLES = 2
) (
    input wire logic clk_sys, // clock
    input wire logic nrst, // reset
    input wire logic op_valid, // request
    input wire csbu_pkg::csbu_op_t op_code, // operation
    input wire logic op_imm, // field operand
    input wire csbu_pkg::csbu_rel_t op_rel, // relation
    input wire logic op_long, // long format
    input wire logic [0:31] pc, // address
    input wire logic [0:31] x_val, // first operand
    input wire logic [0:31] x_pair_val, // first pair low
    input wire logic [0:31] y_val, // second operand
    input wire logic [0:31] y_pair_val, // second pair low
    input wire logic [3:0] y_field, // field
    input wire logic [0:31] disp, // displacement
    input wire logic op_ready, // accept
    input wire logic res_valid, // result pulse
    input wire logic x_wr_en, // write enable
    input wire logic [0:31] x_wr_data, // write data
    input wire logic pair_wr_en, // pair write
    input wire logic [0:31] pair_wr_data, // pair data
    input wire logic pc_valid, // control pulse
    input wire logic [0:31] pc_next, // next address
    input wire logic [0:31] prefetch_addr, // prefetch
    input wire logic mispredict // wrong guess
);
    logic [2:0] low_q;
    logic [4:0] n_q;
    logic [0:31] tgt_q;
    logic [0:31] seq_q;
    wire logic [0:31] disp_ext = op_long ? disp : {{16{disp[16]}}, disp[16:31]};

    // counts the refill gap so its length can be judged when ready returns
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            low_q <= 3'h0;
            n_q <= 5'h00;
            tgt_q <= '0;
            seq_q <= '0;
        end else begin
            low_q <= op_ready ? 3'h0 : low_q + 3'h1;
            n_q <= op_imm ? {1'b0, y_field} : y_val[27:31];
            tgt_q <= pc + disp_ext;
            seq_q <= pc + (op_long ? 32'h6 : 32'h4);
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_one_cycle;
        op_valid && op_ready && op_code != csbu_pkg::OP_NONE |=> res_valid;
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("result pulse missing one cycle after accept");
    property p_no_spurious;
        res_valid |-> $past(op_valid && op_ready);
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("result pulse without an accepted op");
    property p_rotate;
        res_valid && $past(op_code) == csbu_pkg::OP_ROTATE_LEFT
        |-> x_wr_data == (($past(x_val) << n_q) | ($past(x_val) >> (32 - n_q)));
    endproperty
    a_rotate: assert property (p_rotate)
        else $error("rotate result wrong");
    property p_zero_right;
        res_valid && $past(op_code) == csbu_pkg::OP_ZERO_FILL_RIGHT_SHIFT
        |-> x_wr_data == ($past(x_val) >> n_q);
    endproperty
    a_zero_right: assert property (p_zero_right)
        else $error("zero fill right shift wrong");
    property p_sign_right;
        res_valid && $past(op_code) == csbu_pkg::OP_SIGN_FILL_RIGHT_SHIFT
        |-> x_wr_data == $unsigned($signed($past(x_val)) >>> n_q);
    endproperty
    a_sign_right: assert property (p_sign_right)
        else $error("sign fill right shift wrong");
    property p_byte;
        res_valid && $past(op_code) == csbu_pkg::OP_BYTE_SIGN_EXTEND
        |-> x_wr_data == {{24{$past(y_val[24])}}, $past(y_val[24:31])};
    endproperty
    a_byte: assert property (p_byte)
        else $error("byte sign extend wrong");
    property p_unsigned;
        res_valid && $past(op_code) == csbu_pkg::OP_UNSIGNED_COMPARE |-> x_wr_data ==
        ($past(x_val) < $past(y_val) ? csbu_pkg::RES_LESS :
        $past(x_val) == $past(y_val) ? csbu_pkg::RES_EQUAL : csbu_pkg::RES_GREATER);
    endproperty
    a_unsigned: assert property (p_unsigned)
        else $error("unsigned compare wrong");
    property p_jump;
        pc_valid && $past(op_code) == csbu_pkg::OP_RELATIVE_JUMP
        |-> pc_next == tgt_q && prefetch_addr == tgt_q && !mispredict;
    endproperty
    a_jump: assert property (p_jump)
        else $error("unconditional jump target or prefetch wrong");
    property p_predict;
        pc_valid && $past(op_code) == csbu_pkg::OP_COND_JUMP
        |-> prefetch_addr == ($past(disp[31]) ? tgt_q : seq_q);
    endproperty
    a_predict: assert property (p_predict)
        else $error("prefetch not steered by prediction bit");
    property p_mis_fix;
        mispredict |-> !op_ready && pc_next != prefetch_addr;
    endproperty
    a_mis_fix: assert property (p_mis_fix)
        else $error("mispredict without stall or correction");
    property p_refill;
        $rose(op_ready) |-> low_q == REFILL_CYCLES;
    endproperty
    a_refill: assert property (p_refill)
        else $error("refill gap length wrong");

    c_mis: cover property (mispredict);
    c_pair: cover property (pair_wr_en);
    c_call: cover property (pc_valid && x_wr_en);
endmodule : csbu_unit_chk

bind csbu_unit csbu_unit_chk #(.REFILL_CYCLES(REFILL_CYCLES)) csbu_unit_chk_inst (.*);
`default_nettype wire

// [test/tb_top.sv]
// Purpose: directed self-checking bench for the compare, shift and branch unit
// Assumes: refill of two cycles, pc of branch rows fixed at 1000h
// Notes: op codes in the tables are the package encodings
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys, nrst, op_valid, op_imm, op_long;
    csbu_pkg::csbu_op_t op_code;
    csbu_pkg::csbu_rel_t op_rel;
    logic [0:31] pc, x_val, x_pair_val, y_val, y_pair_val, disp;
    logic [3:0] y_field;
    logic op_ready, res_valid, x_wr_en, pair_wr_en, pc_valid, mispredict;
    logic [0:31] x_wr_data, pair_wr_data, pc_next, prefetch_addr;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    typedef struct {logic [4:0] op; logic imm; logic [0:31] x, xp, y, yp; logic [3:0] f;
        logic [0:31] e, ep;} csbu_drow_t;
    typedef struct {logic [4:0] op; logic imm; logic [2:0] rel; logic lng; logic [0:31] x, y;
        logic [3:0] f; logic [0:31] d; logic wr; logic [0:31] ex, npc, pf; logic mis;} csbu_brow_t;
    csbu_drow_t drows [19] = '{
        '{5'h01, 0, 32'h80000000, 0, 32'h1, 0, 4'h9, 32'h1, 0},
        '{5'h01, 0, 32'h5, 0, 32'h5, 0, 4'h9, 32'h0, 0},
        '{5'h01, 0, 32'h1, 0, 32'h2, 0, 4'h9, 32'hffffffff, 0},
        '{5'h02, 0, 32'hffffffff, 0, 32'h0, 32'h1, 4'h9, 32'hffffffff, 0},
        '{5'h02, 0, 32'h0, 32'h80000000, 32'h0, 32'h1, 4'h9, 32'h1, 0},
        '{5'h03, 0, 32'h80000000, 0, 32'h0, 0, 4'h9, 32'h0, 0},
        '{5'h03, 0, 32'hbf800000, 0, 32'hc0000000, 0, 4'h9, 32'h1, 0},
        '{5'h04, 0, 32'hc0000000, 0, 32'h40000000, 0, 4'h9, 32'hffffffff, 0},
        '{5'h04, 0, 32'h3ff00000, 32'h1, 32'h3ff00000, 0, 4'h9, 32'h1, 0},
        '{5'h05, 1, 32'h80000001, 0, 32'h0, 0, 4'h1, 32'h3, 0},
        '{5'h05, 0, 32'h1, 0, 32'h3f, 0, 4'h9, 32'h80000000, 0},
        '{5'h06, 0, 32'hffffffff, 0, 32'h21, 0, 4'h9, 32'hfffffffe, 0},
        '{5'h07, 1, 32'hffffffff, 0, 32'h0, 0, 4'hf, 32'h1ffff, 0},
        '{5'h08, 1, 32'h40000001, 0, 32'h0, 0, 4'h1, 32'h2, 0},
        '{5'h09, 0, 32'h80000000, 0, 32'h1f, 0, 4'h9, 32'hffffffff, 0},
        '{5'h0a, 0, 32'h0, 32'h1, 32'h24, 0, 4'h9, 32'h10, 32'h0},
        '{5'h0b, 1, 32'h12345678, 32'h9abcdef0, 32'h0, 0, 4'h4, 32'h1234567, 32'h89abcdef},
        '{5'h0c, 0, 32'h0, 0, 32'h12345680, 0, 4'h9, 32'hffffff80, 0},
        '{5'h0d, 0, 32'h0, 0, 32'h17fff, 0, 4'h9, 32'h7fff, 0}};
    csbu_brow_t brows [10] = '{
        '{5'h0e, 0, 0, 0, 0, 0, 0, 32'hfff0, 0, 0, 32'hff0, 32'hff0, 0},
        '{5'h0e, 0, 0, 1, 0, 0, 0, 32'h101, 0, 0, 32'h1101, 32'h1101, 0},
        '{5'h0f, 1, 1, 0, 32'hffffffff, 0, 2, 32'h20, 0, 0, 32'h1020, 32'h1004, 1},
        '{5'h0f, 0, 2, 0, 32'h1, 32'hffffffff, 0, 32'h41, 0, 0, 32'h1041, 32'h1041, 0},
        '{5'h0f, 1, 3, 1, 32'h5, 0, 5, 32'h81, 0, 0, 32'h1006, 32'h1081, 1},
        '{5'h10, 1, 0, 0, 32'hfffffffb, 0, 3, 32'h11, 1, 32'hfffffffe, 32'h1011, 32'h1011, 0},
        '{5'h10, 1, 0, 0, 32'hfffffffe, 0, 2, 32'h10, 1, 32'h0, 32'h1004, 32'h1004, 0},
        '{5'h11, 0, 0, 0, 0, 0, 0, 32'hff00, 1, 32'h1004, 32'hf00, 32'hf00, 0},
        '{5'h12, 0, 0, 0, 0, 32'h200, 0, 0, 1, 32'h1002, 32'h1200, 32'h1200, 0},
        '{5'h13, 0, 0, 0, 0, 32'h4000, 0, 0, 1, 32'h1002, 32'h4000, 32'h4000, 0}};

    csbu_unit #(.REFILL_CYCLES(2)) csbu_unit_inst (.*);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [0:31] got, input logic [0:31] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // waits out a refill gap, then holds the op for exactly one accepting edge
    task automatic go();
        int n;
        n = 0;
        @(negedge clk_sys);
        while (op_ready !== 1'b1 && n < 20) begin
            n++;
            @(negedge clk_sys);
        end
        op_valid = 1'b1;
        @(negedge clk_sys);
        op_valid = 1'b0;
    endtask : go

    task automatic t_data();
        csbu_drow_t d;
        foreach (drows[i]) begin
            d = drows[i];
            op_code = csbu_pkg::csbu_op_t'(d.op);
            op_imm = d.imm;
            x_val = d.x;
            x_pair_val = d.xp;
            y_val = d.y;
            y_pair_val = d.yp;
            y_field = d.f;
            go();
            chk({31'h0, res_valid}, 32'h1);
            chk({31'h0, x_wr_en}, 32'h1);
            chk({31'h0, pair_wr_en}, {31'h0, (d.op inside {5'h0a, 5'h0b})});
            chk(x_wr_data, d.e);
            if (d.op inside {5'h0a, 5'h0b}) chk(pair_wr_data, d.ep);
        end
        $display("done data operations");
    endtask : t_data

    task automatic t_branch();
        csbu_brow_t b;
        pc = 32'h1000;
        foreach (brows[i]) begin
            b = brows[i];
            op_code = csbu_pkg::csbu_op_t'(b.op);
            op_imm = b.imm;
            op_rel = csbu_pkg::csbu_rel_t'(b.rel);
            op_long = b.lng;
            x_val = b.x;
            y_val = b.y;
            y_field = b.f;
            disp = b.d;
            go();
            chk({31'h0, pc_valid}, 32'h1);
            chk(pc_next, b.npc);
            chk(prefetch_addr, b.pf);
            chk({31'h0, mispredict}, {31'h0, b.mis});
            chk({31'h0, x_wr_en}, {31'h0, b.wr});
            if (b.wr) chk(x_wr_data, b.ex);
            if (b.mis) begin
                chk({31'h0, op_ready}, 32'h0);
                @(negedge clk_sys);
                @(negedge clk_sys);
                chk({31'h0, op_ready}, 32'h1);
            end
        end
        $display("done branch operations");
    endtask : t_branch

    // equal operands under every relation; not-taken ones also stall on refill
    task automatic t_rel();
        logic [0:5] taken;
        taken = 6'b100011;
        for (int r = 0; r < 6; r++) begin
            op_code = csbu_pkg::OP_COND_JUMP;
            op_rel = csbu_pkg::csbu_rel_t'(r);
            op_imm = 1'b1;
            op_long = 1'b0;
            x_val = 32'h3;
            y_field = 4'h3;
            pc = 32'h2000;
            disp = 32'h101;
            go();
            chk(pc_next, taken[r] ? 32'h2101 : 32'h2004);
        end
        $display("done relations");
    endtask : t_rel

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        nrst = 1'b0;
        op_valid = 1'b0;
        op_code = csbu_pkg::OP_NONE;
        op_imm = 1'b0;
        op_rel = csbu_pkg::REL_EQ;
        op_long = 1'b0;
        pc = 32'h0;
        x_val = 32'h0;
        x_pair_val = 32'h0;
        y_val = 32'h0;
        y_pair_val = 32'h0;
        y_field = 4'h0;
        disp = 32'h0;
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_data();
        t_branch();
        t_rel();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
